//--- inc/sdb_pkg.sv
// shared constants for the double-rate burst-of-two static memory port
// assumes one clock aclk; the memory's k/k_n clocks are levels toggled by the controller
package sdb_pkg;
	localparam int SDB_ADDR_W = 4;
	localparam int SDB_BEAT_W = 18;
	localparam int SDB_BYTE_W = 9;
	localparam int SDB_NBYTE = SDB_BEAT_W / SDB_BYTE_W;
	localparam int SDB_WORD_W = 2 * SDB_BEAT_W;
	localparam int SDB_CODE_W = 5;
	localparam logic [SDB_CODE_W-1:0] SDB_CODE_RST = 5'h10;
	localparam int SDB_CAL_PERIOD_CYC = 1024;
	// controller register map, byte offsets
	localparam logic [7:0] SDB_REG_CTRL = 8'h00;
	localparam logic [7:0] SDB_REG_ADDR = 8'h04;
	localparam logic [7:0] SDB_REG_WD0 = 8'h08;
	localparam logic [7:0] SDB_REG_WD1 = 8'h0C;
	localparam logic [7:0] SDB_REG_MASK = 8'h10;
	localparam logic [7:0] SDB_REG_RD0 = 8'h14;
	localparam logic [7:0] SDB_REG_RD1 = 8'h18;
	localparam logic [7:0] SDB_REG_STAT = 8'h1C;
	localparam int SDB_CTRL_WR_BIT = 0;
	localparam int SDB_CTRL_RD_BIT = 1;
	localparam int SDB_CTRL_TERM_BIT = 2;
	localparam int SDB_CTRL_PLLOFF_BIT = 3;
	localparam int SDB_STAT_WRP_BIT = 0;
	localparam int SDB_STAT_RDB_BIT = 1;
	localparam int SDB_STAT_DONE_BIT = 2;
	localparam logic [3:0] SDB_MASK_RST = 4'h0;
	localparam logic [1:0] SDB_RESP_OKAY = 2'h0;
	localparam logic [1:0] SDB_RESP_SLVERR = 2'h2;
endpackage

//--- inc/sdb_if.sv
// pins between the memory device and its controller
// assumes both ends run on aclk; k high marks the primary-edge slot
interface sdb_if;
	import sdb_pkg::*;
	logic k;
	logic k_n;
	logic [SDB_ADDR_W-1:0] addr_in;
	logic rd_n;
	logic wr_n;
	logic [SDB_BEAT_W-1:0] data_in;
	logic [SDB_NBYTE-1:0] byte_mask_n;
	logic [SDB_BEAT_W-1:0] data_out;
	logic data_out_oe_n;
	logic echo_clock;
	logic echo_clock_n;
	logic out_valid;
	logic term_enable;
	logic pll_off_n;
	modport dev (input k, k_n, addr_in, rd_n, wr_n, data_in, byte_mask_n, term_enable,
		pll_off_n, output data_out, data_out_oe_n, echo_clock, echo_clock_n, out_valid);
	modport ctl (output k, k_n, addr_in, rd_n, wr_n, data_in, byte_mask_n, term_enable,
		pll_off_n, input data_out, data_out_oe_n, echo_clock, echo_clock_n, out_valid);
endinterface

//--- design/sdb_imp_cal.sv
// periodic one-step impedance calibration engine
// assumes up/dn come from an analog comparator, hence synchronised here
module sdb_imp_cal import sdb_pkg::*; #(
	parameter int CAL_CYC = SDB_CAL_PERIOD_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic cmp_up,
	input wire logic cmp_dn,
	output logic [SDB_CODE_W-1:0] code
);
	logic [1:0] up_s_q;
	logic [1:0] dn_s_q;
	logic [$clog2(CAL_CYC+1)-1:0] cnt_q;
	logic [SDB_CODE_W-1:0] code_q;
	wire eval = (cnt_q == ($clog2(CAL_CYC+1))'(CAL_CYC - 1));
	wire step_up = up_s_q[1] & ~dn_s_q[1] & (code_q != '1);
	wire step_dn = dn_s_q[1] & ~up_s_q[1] & (code_q != '0);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			up_s_q <= 2'h0;
			dn_s_q <= 2'h0;
			cnt_q <= '0;
			code_q <= SDB_CODE_RST;
		end else begin
			up_s_q <= {up_s_q[0], cmp_up};
			dn_s_q <= {dn_s_q[0], cmp_dn};
			cnt_q <= eval ? '0 : cnt_q + 1'b1;
			if (eval && step_up) begin
				code_q <= code_q + 1'b1;
			end else if (eval && step_dn) begin
				code_q <= code_q - 1'b1;
			end
		end
	end

	assign code = code_q;
endmodule

//--- design/sdb_sram_port.sv
// memory device end: separate read and write ports, burst of two, double rate
// assumes the controller toggles k each aclk; k high at an edge is the primary slot
// Operation
// - address and read command captured each primary edge
// - read low starts read, high deselects
// - beats at n+2 primary and inverted edges
// - write command primary edge, address inverted edge
// - write low starts write, high deselects
// - controller sends beat one with command
// - masks sampled with each data beat
// - masked byte keeps its old contents
// - one address stores two beats
// - counter triggers one-step driver calibration
// - termination follows termination-select pin
// - termination code recalibrated the same way
// - controller never floats terminated inputs
// - pll-off pin low bypasses the loop
// - mask zero low byte, one high
module sdb_sram_port import sdb_pkg::*; #(
	parameter int DEPTH = 2 ** SDB_ADDR_W,
	parameter int CAL_CYC = SDB_CAL_PERIOD_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	sdb_if.dev port,
	input wire logic drv_cmp_up,
	input wire logic drv_cmp_dn,
	input wire logic term_cmp_up,
	input wire logic term_cmp_dn,
	output logic [SDB_CODE_W-1:0] drive_code,
	output logic [SDB_CODE_W-1:0] term_code,
	output logic term_active,
	output logic pll_bypass
);
	// byte-masked merge of one beat into the old contents
	function automatic logic [SDB_BEAT_W-1:0] beat_merge(
		input logic [SDB_BEAT_W-1:0] old_v,
		input logic [SDB_BEAT_W-1:0] new_v,
		input logic [SDB_NBYTE-1:0] mask_n
	);
		logic [SDB_BEAT_W-1:0] res;
		res = old_v;
		for (int b = 0; b < SDB_NBYTE; b++) begin
			if (!mask_n[b]) begin
				res[b*SDB_BYTE_W +: SDB_BYTE_W] = new_v[b*SDB_BYTE_W +: SDB_BYTE_W];
			end
		end
		return res;
	endfunction

	// one beat of a stored word; the first beat is the low half
	function automatic logic [SDB_BEAT_W-1:0] word_beat(
		input logic [SDB_WORD_W-1:0] w,
		input logic second
	);
		return second ? w[SDB_WORD_W-1:SDB_BEAT_W] : w[SDB_BEAT_W-1:0];
	endfunction

	logic [SDB_WORD_W-1:0] mem_q [DEPTH];
	// write half-burst held between the two slots
	logic wr_arm_q;
	logic [SDB_BEAT_W-1:0] wbeat0_q;
	logic [SDB_NBYTE-1:0] wmask0_q;
	// read pipeline, two primary cycles deep
	logic rd1_v_q;
	logic [SDB_ADDR_W-1:0] rd1_a_q;
	logic rd2_v_q;
	logic [SDB_ADDR_W-1:0] rd2_a_q;
	logic rbeat_v_q;
	logic [SDB_ADDR_W-1:0] rbeat_a_q;
	// pin registers
	logic [SDB_BEAT_W-1:0] dout_q;
	logic dout_oe_n_q;
	logic valid_q;
	logic echo_q;
	logic echo_n_q;
	logic term_q;
	logic pll_bypass_q;

	// k is a level from the controller's flop, so the slots need no synchroniser
	wire k_slot = port.k;
	wire kb_slot = ~port.k;
	wire rd_cmd = k_slot & ~port.rd_n;
	wire wr_cmd = k_slot & ~port.wr_n;
	wire wr_commit = kb_slot & wr_arm_q;
	wire [SDB_WORD_W-1:0] wr_old = mem_q[port.addr_in];
	wire [SDB_BEAT_W-1:0] wr_lo = beat_merge(word_beat(wr_old, 1'b0), wbeat0_q, wmask0_q);
	wire [SDB_BEAT_W-1:0] wr_hi = beat_merge(word_beat(wr_old, 1'b1), port.data_in,
		port.byte_mask_n);
	// beat two reads by its own held address, so back-to-back reads never mix words
	wire [SDB_WORD_W-1:0] rd_word0 = mem_q[rd2_a_q];
	wire [SDB_WORD_W-1:0] rd_word1 = mem_q[rbeat_a_q];
	wire [SDB_BEAT_W-1:0] rd_beat0 = word_beat(rd_word0, 1'b0);
	wire [SDB_BEAT_W-1:0] rd_beat1 = word_beat(rd_word1, 1'b1);
	wire beat0_go = k_slot & rd2_v_q;
	wire beat1_go = kb_slot & rbeat_v_q;

	// storage has no reset, like the array it models
	always_ff @(posedge aclk) begin
		if (wr_commit) begin
			mem_q[port.addr_in] <= {wr_hi, wr_lo};
		end
	end

	// write port: command, beat one and its mask on the primary slot
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_arm_q <= 1'b0;
			wbeat0_q <= '0;
			wmask0_q <= '1;
		end else if (k_slot) begin
			wr_arm_q <= wr_cmd;
			wbeat0_q <= port.data_in;
			wmask0_q <= port.byte_mask_n;
		end else begin
			wr_arm_q <= 1'b0;
		end
	end

	// read port runs beside the write port, no arbitration needed
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd1_v_q <= 1'b0;
			rd1_a_q <= '0;
			rd2_v_q <= 1'b0;
			rd2_a_q <= '0;
		end else if (k_slot) begin
			rd1_v_q <= rd_cmd;
			rd1_a_q <= port.addr_in;
			rd2_v_q <= rd1_v_q;
			rd2_a_q <= rd1_a_q;
		end
	end

	// output beats; the array is read late so earlier writes are seen
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rbeat_v_q <= 1'b0;
			rbeat_a_q <= '0;
			dout_q <= '0;
			dout_oe_n_q <= 1'b1;
			valid_q <= 1'b0;
		end else if (beat0_go) begin
			rbeat_v_q <= 1'b1;
			rbeat_a_q <= rd2_a_q;
			dout_q <= rd_beat0;
			dout_oe_n_q <= 1'b0;
			valid_q <= 1'b1;
		end else if (beat1_go) begin
			rbeat_v_q <= 1'b0;
			dout_q <= rd_beat1;
			dout_oe_n_q <= 1'b0;
			valid_q <= 1'b1;
		end else begin
			rbeat_v_q <= 1'b0;
			dout_q <= '0;
			dout_oe_n_q <= 1'b1;
			valid_q <= 1'b0;
		end
	end

	// echo pair updates on the same edge as the data beats
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			echo_q <= 1'b0;
			echo_n_q <= 1'b1;
		end else begin
			echo_q <= port.k;
			echo_n_q <= port.k_n;
		end
	end

	// static mode pins; registered so the status outputs come from flops
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			term_q <= 1'b0;
			pll_bypass_q <= 1'b0;
		end else begin
			term_q <= port.term_enable;
			pll_bypass_q <= ~port.pll_off_n;
		end
	end

	sdb_imp_cal #(.CAL_CYC(CAL_CYC)) u_drv_cal (
		.aclk(aclk),
		.aresetn(aresetn),
		.cmp_up(drv_cmp_up),
		.cmp_dn(drv_cmp_dn),
		.code(drive_code)
	);

	// termination shares the engine so both codes track drift alike
	sdb_imp_cal #(.CAL_CYC(CAL_CYC)) u_term_cal (
		.aclk(aclk),
		.aresetn(aresetn),
		.cmp_up(term_cmp_up),
		.cmp_dn(term_cmp_dn),
		.code(term_code)
	);

	assign port.data_out = dout_q;
	assign port.data_out_oe_n = dout_oe_n_q;
	assign port.out_valid = valid_q;
	assign port.echo_clock = echo_q;
	assign port.echo_clock_n = echo_n_q;
	assign term_active = term_q;
	assign pll_bypass = pll_bypass_q;
endmodule

//--- design/sdb_mem_ctl.sv
// controller end: AXI4-Lite register slave that drives the memory pins
// assumes the device end shares aclk; one write and one read burst at a time
//
// The implementer's own choices: the AXI4-Lite slave port and the address map.
module sdb_mem_ctl import sdb_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	sdb_if.ctl port,
	input wire logic awvalid,
	output logic awready,
	input wire logic [7:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [7:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp
);
	function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction

	function automatic logic known_reg(input logic [7:0] a);
		return a[1:0] == 2'h0 && a <= SDB_REG_STAT;
	endfunction

	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q, aw_have_q, w_have_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q, rdata_q;
	logic [3:0] wstrb_q;
	logic [1:0] bresp_q, rresp_q;
	logic [3:0] ctrl_q, mask_q;
	logic [SDB_ADDR_W-1:0] addr_q;
	logic [SDB_BEAT_W-1:0] wd0_q, wd1_q, rd0_q, rd1_q;
	logic wr_pend_q, rd_pend_q, rd_busy_q, rd_done_q;
	logic k_q, rd_n_q, wr_n_q;
	logic [SDB_ADDR_W-1:0] pin_addr_q;
	logic [SDB_BEAT_W-1:0] pin_data_q;
	logic [SDB_NBYTE-1:0] pin_mask_q;

	wire reg_wr = aw_have_q & w_have_q & ~bvalid_q;
	wire [31:0] wv = strb_merge(32'h0000_0000, wdata_q, wstrb_q);
	wire wr_ctrl = reg_wr & (awaddr_q == SDB_REG_CTRL);
	wire wr_stat = reg_wr & (awaddr_q == SDB_REG_STAT);
	wire issue = ~k_q; // next edge the device sees its primary slot
	wire do_wr = issue & wr_pend_q;
	wire do_rd = issue & rd_pend_q;
	wire beat0_in = port.out_valid & port.echo_clock;
	wire beat1_in = port.out_valid & ~port.echo_clock;
	wire [31:0] stat_v = {29'h0, rd_done_q, rd_busy_q | rd_pend_q, wr_pend_q};
	wire [31:0] rd_mux = (araddr == SDB_REG_CTRL) ? {28'h0, ctrl_q} :
		(araddr == SDB_REG_ADDR) ? 32'(addr_q) :
		(araddr == SDB_REG_WD0) ? 32'(wd0_q) :
		(araddr == SDB_REG_WD1) ? 32'(wd1_q) :
		(araddr == SDB_REG_MASK) ? {28'h0, mask_q} :
		(araddr == SDB_REG_RD0) ? 32'(rd0_q) :
		(araddr == SDB_REG_RD1) ? 32'(rd1_q) :
		(araddr == SDB_REG_STAT) ? stat_v : 32'h0000_0000;

	// bus handshakes; address and data may arrive in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= SDB_RESP_OKAY;
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= SDB_RESP_OKAY;
		end else begin
			if (awvalid && awready_q) begin
				awaddr_q <= awaddr;
				aw_have_q <= 1'b1;
				awready_q <= 1'b0;
			end
			if (wvalid && wready_q) begin
				wdata_q <= wdata;
				wstrb_q <= wstrb;
				w_have_q <= 1'b1;
				wready_q <= 1'b0;
			end
			if (reg_wr) begin
				bvalid_q <= 1'b1;
				bresp_q <= known_reg(awaddr_q) ? SDB_RESP_OKAY : SDB_RESP_SLVERR;
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
			end
			if (bvalid_q && bready) begin
				bvalid_q <= 1'b0;
				awready_q <= 1'b1;
				wready_q <= 1'b1;
			end
			if (arvalid && arready_q) begin
				arready_q <= 1'b0;
				rvalid_q <= 1'b1;
				rdata_q <= rd_mux;
				rresp_q <= known_reg(araddr) ? SDB_RESP_OKAY : SDB_RESP_SLVERR;
			end else if (rvalid_q && rready) begin
				rvalid_q <= 1'b0;
				arready_q <= 1'b1;
			end
		end
	end

	// registers, pending orders and returned read beats
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= 4'h0;
			mask_q <= SDB_MASK_RST;
			addr_q <= '0;
			wd0_q <= '0;
			wd1_q <= '0;
			rd0_q <= '0;
			rd1_q <= '0;
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			rd_busy_q <= 1'b0;
			rd_done_q <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= {wv[SDB_CTRL_PLLOFF_BIT], wv[SDB_CTRL_TERM_BIT], 2'h0};
			end
			if (reg_wr && awaddr_q == SDB_REG_ADDR) addr_q <= wv[SDB_ADDR_W-1:0];
			if (reg_wr && awaddr_q == SDB_REG_WD0) wd0_q <= wv[SDB_BEAT_W-1:0];
			if (reg_wr && awaddr_q == SDB_REG_WD1) wd1_q <= wv[SDB_BEAT_W-1:0];
			if (reg_wr && awaddr_q == SDB_REG_MASK) mask_q <= wv[3:0];
			if (wr_ctrl && wv[SDB_CTRL_WR_BIT]) begin
				wr_pend_q <= 1'b1;
			end else if (do_wr) begin
				wr_pend_q <= 1'b0;
			end
			// a read start while a read is in flight is dropped
			if (wr_ctrl && wv[SDB_CTRL_RD_BIT] && !rd_busy_q) begin
				rd_pend_q <= 1'b1;
			end else if (do_rd) begin
				rd_pend_q <= 1'b0;
			end
			if (do_rd) begin
				rd_busy_q <= 1'b1;
			end else if (beat1_in && rd_busy_q) begin
				rd_busy_q <= 1'b0;
			end
			if (beat0_in) rd0_q <= port.data_out;
			if (beat1_in) rd1_q <= port.data_out;
			// set wins over the software clear
			if (beat1_in && rd_busy_q) begin
				rd_done_q <= 1'b1;
			end else if (wr_stat && wv[SDB_STAT_DONE_BIT]) begin
				rd_done_q <= 1'b0;
			end
		end
	end

	// pin side: k toggles every aclk; command and beat one on k high
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			k_q <= 1'b0;
			rd_n_q <= 1'b1;
			wr_n_q <= 1'b1;
			pin_addr_q <= '0;
			pin_data_q <= '0;
			pin_mask_q <= '1;
		end else begin
			k_q <= ~k_q;
			if (issue) begin
				rd_n_q <= ~do_rd;
				wr_n_q <= ~do_wr;
				pin_addr_q <= addr_q;
				pin_data_q <= wd0_q;
				pin_mask_q <= mask_q[1:0];
			end else begin
				rd_n_q <= 1'b1;
				wr_n_q <= 1'b1;
				pin_addr_q <= addr_q;
				pin_data_q <= wd1_q;
				pin_mask_q <= mask_q[3:2];
			end
		end
	end

	assign awready = awready_q;
	assign wready = wready_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = arready_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;
	assign port.k = k_q;
	assign port.k_n = ~k_q;
	assign port.rd_n = rd_n_q;
	assign port.wr_n = wr_n_q;
	assign port.addr_in = pin_addr_q;
	assign port.data_in = pin_data_q;
	assign port.byte_mask_n = pin_mask_q;
	assign port.term_enable = ctrl_q[SDB_CTRL_TERM_BIT];
	assign port.pll_off_n = ~ctrl_q[SDB_CTRL_PLLOFF_BIT];
endmodule

//--- sim/sdb_port_sva.sv
// assertions on the pins joining the memory device and its controller
// assumes it sits beside the interface instance; aresetn synchronous active low
module sdb_port_sva import sdb_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic k,
	input wire logic k_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic data_out_oe_n,
	input wire logic echo_clock,
	input wire logic echo_clock_n,
	input wire logic out_valid
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	wire rd_go = k && !rd_n;
	// beats seen five edges after the primary slot that took the read
	a_read_beat_lat: assert property (
		rd_go |-> ##5 (out_valid && echo_clock) ##1 (out_valid && !echo_clock))
		else $error("read beats missing after read command");
	a_read_origin: assert property (
		$rose(out_valid) |-> $past(rd_go, 5))
		else $error("output beat without read command");
	a_idle_hiz: assert property (!out_valid |-> data_out_oe_n)
		else $error("outputs driven outside a read");
	a_valid_echo: assert property (
		out_valid |-> !data_out_oe_n && (echo_clock != echo_clock_n))
		else $error("valid beat without drive or echo pair");
	a_rd_primary: assert property (!rd_n |-> k)
		else $error("read command outside primary slot");
	a_wr_primary: assert property (!wr_n |-> k ##1 (!k && wr_n))
		else $error("write command not a single primary slot");
	a_clk_toggle: assert property (k |=> !k && k_n)
		else $error("primary clock did not toggle");
	a_clk_pair: assert property (k != k_n)
		else $error("clock pair not complementary");
	cover property (rd_go);
	cover property (k && !wr_n);
	cover property (rd_go && !wr_n);
	cover property ($rose(out_valid));
endmodule

//--- sim/sdb_sram_port_tb_top.sv
// testbench joining controller and memory device through the pin interface
// assumes AXI4-Lite host only; comparators driven directly by the bench
module sdb_sram_port_tb_top import sdb_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic awvalid, wvalid, arvalid, bready, rready, awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, ctl_hi;
	logic drv_up, drv_dn, term_up, term_dn, term_active, pll_bypass;
	logic [SDB_CODE_W-1:0] drive_code, term_code;
	int fails = 0;
	int n_compared = 0;
	int cycles = 0;
	sdb_if u_sdb_if();
	sdb_sram_port #(.CAL_CYC(8)) u_sdb_sram_port(.aclk(aclk), .aresetn(aresetn),
		.port(u_sdb_if), .drv_cmp_up(drv_up), .drv_cmp_dn(drv_dn), .term_cmp_up(term_up),
		.term_cmp_dn(term_dn), .drive_code(drive_code), .term_code(term_code),
		.term_active(term_active), .pll_bypass(pll_bypass));
	sdb_mem_ctl u_sdb_mem_ctl(.aclk(aclk), .aresetn(aresetn), .port(u_sdb_if),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
		.wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
		.bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));
	sdb_port_sva u_sdb_port_sva(.aclk(aclk), .aresetn(aresetn), .k(u_sdb_if.k),
		.k_n(u_sdb_if.k_n), .rd_n(u_sdb_if.rd_n), .wr_n(u_sdb_if.wr_n),
		.data_out_oe_n(u_sdb_if.data_out_oe_n), .echo_clock(u_sdb_if.echo_clock),
		.echo_clock_n(u_sdb_if.echo_clock_n), .out_valid(u_sdb_if.out_valid));
	always #2 aclk = ~aclk;
	task automatic test_done();
		if (fails == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// run needs well under two thousand cycles
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			fails = fails + 1;
			test_done();
		end
	end
	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		n_compared++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			fails++;
		end
	endtask
	// bready and rready held high, so the answer edge is the handshake edge
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		forever begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		chk(bresp, er);
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		arvalid <= 1'b1;
		araddr <= a;
		forever begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		d = rdata;
		chk(rresp, er);
	endtask
	// one burst: go bit0 writes d, bit1 reads back and expects exp
	task automatic xfer(input logic [3:0] a, input logic [35:0] d, input logic [3:0] m,
			input logic [1:0] go, input logic [35:0] exp);
		logic [31:0] s;
		logic [31:0] r0;
		logic [31:0] r1;
		axi_wr(SDB_REG_ADDR, {28'h0, a}, SDB_RESP_OKAY);
		axi_wr(SDB_REG_WD0, {14'h0, d[17:0]}, SDB_RESP_OKAY);
		axi_wr(SDB_REG_WD1, {14'h0, d[35:18]}, SDB_RESP_OKAY);
		axi_wr(SDB_REG_MASK, {28'h0, m}, SDB_RESP_OKAY);
		axi_wr(SDB_REG_CTRL, {28'h0, ctl_hi, go}, SDB_RESP_OKAY);
		for (int i = 0; i < 40; i++) begin
			axi_rd(SDB_REG_STAT, s, SDB_RESP_OKAY);
			if (s[SDB_STAT_WRP_BIT] === 1'b0 && s[SDB_STAT_RDB_BIT] === 1'b0) break;
		end
		chk({s[SDB_STAT_WRP_BIT], s[SDB_STAT_RDB_BIT]}, 2'b00);
		if (go[1]) begin
			chk(s[SDB_STAT_DONE_BIT], 1'b1);
			axi_rd(SDB_REG_RD0, r0, SDB_RESP_OKAY);
			axi_rd(SDB_REG_RD1, r1, SDB_RESP_OKAY);
			chk({r1[17:0], r0[17:0]}, exp);
			axi_wr(SDB_REG_STAT, 32'h0000_0004, SDB_RESP_OKAY);
		end
	endtask
	// window of 8 cycles holds exactly one evaluation
	task automatic t_cal();
		logic [4:0] pd;
		logic [4:0] pt;
		chk({drive_code, term_code}, {SDB_CODE_RST, SDB_CODE_RST});
		drv_up <= 1'b1;
		term_dn <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			pd = drive_code;
			pt = term_code;
			repeat (8) @(posedge aclk);
			chk(drive_code == pd || drive_code == pd + 5'h01, 1'b1);
			chk(term_code == pt || term_code == pt - 5'h01, 1'b1);
		end
		chk(drive_code > SDB_CODE_RST && term_code < SDB_CODE_RST, 1'b1);
		// both comparator levels high means hold, just as neither does
		drv_dn <= 1'b1;
		term_dn <= 1'b0;
		repeat (16) @(posedge aclk);
		pd = drive_code;
		pt = term_code;
		repeat (24) @(posedge aclk);
		chk({drive_code, term_code}, {pd, pt});
		drv_up <= 1'b0;
		pd = drive_code;
		repeat (24) @(posedge aclk);
		chk(drive_code < pd, 1'b1);
		drv_dn <= 1'b0;
	endtask
	task automatic t_bus();
		logic [31:0] r;
		axi_rd(SDB_REG_MASK, r, SDB_RESP_OKAY);
		chk(r[3:0], SDB_MASK_RST);
		axi_wr(8'h20, 32'h0000_0001, SDB_RESP_SLVERR);
		axi_wr(8'h05, 32'h0000_0001, SDB_RESP_SLVERR);
		axi_rd(8'h24, r, SDB_RESP_SLVERR);
		chk(r, 32'h0000_0000);
		axi_wr(SDB_REG_WD1, 32'hffff_ffff, SDB_RESP_OKAY);
		axi_rd(SDB_REG_WD1, r, SDB_RESP_OKAY);
		chk(r, 32'h0003_ffff);
		axi_wr(SDB_REG_ADDR, 32'hffff_fffa, SDB_RESP_OKAY);
		axi_rd(SDB_REG_ADDR, r, SDB_RESP_OKAY);
		chk(r, 32'h0000_000a);
	endtask
	task automatic t_burst();
		xfer(4'h3, 36'h5_a5a5_1c3e, 4'h0, 2'b01, 36'h0);
		xfer(4'h4, 36'hc_3c3c_e1f0, 4'h0, 2'b01, 36'h0);
		xfer(4'h3, 36'h0, 4'h0, 2'b10, 36'h5_a5a5_1c3e);
		xfer(4'h4, 36'h0, 4'h0, 2'b10, 36'hc_3c3c_e1f0);
	endtask
	// beat one keeps high byte, beat two keeps low byte
	task automatic t_mask();
		logic [35:0] o;
		logic [35:0] n;
		o = 36'h1_2345_6789;
		n = 36'he_dcba_9876;
		xfer(4'h5, o, 4'h0, 2'b01, 36'h0);
		xfer(4'h5, n, 4'h6, 2'b01, 36'h0);
		xfer(4'h5, 36'h0, 4'h0, 2'b10, {n[35:27], o[26:18], o[17:9], n[8:0]});
		xfer(4'h5, 36'hf_ffff_ffff, 4'hf, 2'b01, 36'h0);
		xfer(4'h5, 36'h0, 4'h0, 2'b10, {n[35:27], o[26:18], o[17:9], n[8:0]});
	endtask
	task automatic t_both();
		xfer(4'hf, 36'h3_0f0f_55aa, 4'h0, 2'b11, 36'h3_0f0f_55aa);
	endtask
	task automatic t_pins();
		logic [31:0] r;
		ctl_hi = 2'b11;
		axi_wr(SDB_REG_CTRL, {28'h0, ctl_hi, 2'b00}, SDB_RESP_OKAY);
		axi_rd(SDB_REG_CTRL, r, SDB_RESP_OKAY);
		chk(r, 32'h0000_000c);
		repeat (3) @(posedge aclk);
		chk({u_sdb_if.term_enable, term_active, u_sdb_if.pll_off_n, pll_bypass}, 4'hd);
		ctl_hi = 2'b00;
		axi_wr(SDB_REG_CTRL, {28'h0, ctl_hi, 2'b00}, SDB_RESP_OKAY);
		repeat (3) @(posedge aclk);
		chk({u_sdb_if.term_enable, term_active, u_sdb_if.pll_off_n, pll_bypass}, 4'h2);
	endtask
	initial begin
		{awvalid, wvalid, arvalid, drv_up, drv_dn, term_up, term_dn} = 7'h00;
		{awaddr, araddr, wdata} = 48'h0;
		wstrb = 4'hf;
		bready = 1'b1;
		rready = 1'b1;
		ctl_hi = 2'b00;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		t_cal();
		t_bus();
		t_burst();
		t_mask();
		t_both();
		t_pins();
		test_done();
	end
endmodule
